// >>> hw/odc_pkg.sv
// Shared constants for the octal converter serial command logic
package odc_pkg;
  // Frame and word layout
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [4:0] FRAME_FULL = 5'h10;
  localparam int BIT_KIND = 15;
  localparam int BIT_RESET_ALL = 12;
  localparam int CODE_W = 12;
  localparam int NUM_CH = 8;
  // Control function codes in bits 14:13
  localparam logic [1:0] FN_REF = 2'h0;
  localparam logic [1:0] FN_LOAD = 2'h1;
  localparam logic [1:0] FN_PDOWN = 2'h2;
  localparam logic [1:0] FN_RESET = 2'h3;
  // Load-mode codes
  localparam logic [1:0] LDM_CONT = 2'h0;
  localparam logic [1:0] LDM_LATCH = 2'h1;
  localparam logic [1:0] LDM_SINGLE = 2'h2;
  localparam logic [1:0] LDM_RSVD = 2'h3;
  // Reference setup field positions (low bit = group A-D)
  localparam int POS_SUPPLY = 0;
  localparam int POS_BUF = 2;
  localparam int POS_GAIN = 4;
  // Power-on values
  localparam logic [1:0] RST_LOAD_MODE = LDM_LATCH;
  localparam logic [1:0] RST_GROUP = 2'h0;
  localparam logic [7:0] RST_PDOWN = 8'h00;
  localparam logic [CODE_W-1:0] RST_CODE = 12'h000;
  localparam logic RST_LINK_EN = 1'b1;
  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_COUNT = 8'h04;
  localparam logic [7:0] REG_CONTROL = 8'h08;
  localparam logic [7:0] REG_CODE_BASE = 8'h20;
  localparam logic [7:0] REG_CODE_LAST = 8'h3C;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> hw/odc_shifter.sv
// Serial frame shifter: edge detect, bit count, frame end
`timescale 1ns/1ps
module odc_shifter
  import odc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Synchronised link pins
  input wire logic sclk_s,
  input wire logic din_s,
  input wire logic sync_n_s,
  // Frame results
  output logic [FRAME_BITS-1:0] word,
  output logic frame_done,
  output logic frame_abort
);
  logic sclk_prev_ff;
  logic sync_prev_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [FRAME_BITS-1:0] shift_ff;
  logic [FRAME_BITS-1:0] word_ff;
  logic done_ff;
  logic abort_ff;
  logic sclk_fall;

  assign sclk_fall = sclk_prev_ff && !sclk_s;

  // Shift on falling link clock while strobe low, close on strobe rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_prev_ff <= 1'b1; // Idle link clock level
      sync_prev_ff <= 1'b1;
      cnt_ff <= '0;
      shift_ff <= '0;
      word_ff <= '0;
      done_ff <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      sclk_prev_ff <= sclk_s;
      sync_prev_ff <= sync_n_s;
      done_ff <= 1'b0;
      abort_ff <= 1'b0;
      if (sync_n_s) begin
        cnt_ff <= '0;
        if (!sync_prev_ff) begin
          if (cnt_ff == FRAME_FULL) begin
            word_ff <= shift_ff;
            done_ff <= 1'b1;
          end else begin
            abort_ff <= 1'b1;
          end
        end
      end else if (sclk_fall && cnt_ff != FRAME_FULL) begin
        shift_ff <= {shift_ff[FRAME_BITS-2:0], din_s};
        cnt_ff <= cnt_ff + 5'h01;
      end
    end
  end

  assign word = word_ff;
  assign frame_done = done_ff;
  assign frame_abort = abort_ff;
endmodule

// >>> hw/odc_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module odc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // First stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= INIT;
      q_ff <= INIT;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule

// >>> hw/odc_top.sv
// Octal converter command logic: frame decode, code banks, AXI4-Lite
// What this block does
// - Sixteen-bit shift register takes one bit per falling link clock edge.
// - Bits are accepted only while the active-low frame strobe is low.
// - Strobe rising before sixteen bits abandons the frame; only the abort count changes.
// - Words go MSB first; bit 15 zero is data, one is control.
// - A complete data frame loads the addressed channel input register.
// - Bits 14 to 12 address channels A (000) through H (111).
// - Twelve data bits; lower resolutions drop two or four low bits.
// - Codes are straight binary, zero to full scale.
// - Control bits 14:13 pick reference, load mode, power-down, reset.
// - Reference word bit 2 buffers A-D, bit 3 buffers E-H.
// - Reference word bit 4 doubles A-D range, bit 5 E-H.
// - Bits 0 and 1 pick supply reference per group, overriding buffering.
// - Supply-referenced group is forced unbuffered and unity range.
// - Power-down keeps codes and still accepts writes to them.
// - A powered-down channel presents its output as disconnected.
// - Power-on clears codes; normal, unbuffered, unity range until written.
// - Power-down word bits 7 to 0 map channels H to A.
// - Reset word clears codes; with bit 12 also all settings.
// - Load-mode bits: continuous, latched default, single update, reserved.
// - Outputs copy changed inputs while load pin low or mode continuous.
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module odc_top
  import odc_pkg::*;
#(
  parameter int RES_BITS = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial link pins
  input wire logic sclk,
  input wire logic din,
  input wire logic sync_n,
  input wire logic load_outputs_n,
  // Channel outputs
  output logic [NUM_CH*CODE_W-1:0] dac_code,
  output logic [NUM_CH-1:0] chan_hiz,
  output logic [1:0] ref_buffered,
  output logic [1:0] ref_supply,
  output logic [1:0] gain_double,
  // AXI4-Lite write
  input wire logic [odc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [odc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam logic [CODE_W-1:0] RES_MASK =
    CODE_W'({CODE_W{1'b1}} << (CODE_W - RES_BITS));

  logic sclk_s, din_s, sync_n_s, load_n_s;
  logic [FRAME_BITS-1:0] word;
  logic frame_done, frame_abort;
  logic link_en_ff;
  logic is_data, is_ctrl, data_reset, ctrl_reset;
  logic [1:0] fn;
  logic [2:0] data_ch;
  logic [CODE_W-1:0] data_val;
  logic single_ff, load_now;
  logic [NUM_CH-1:0][CODE_W-1:0] in_code_ff;
  logic [NUM_CH-1:0][CODE_W-1:0] out_code_ff;
  logic [NUM_CH-1:0] dirty_ff;
  logic [1:0] gain_ff, buf_ff, supply_ff, load_mode_ff;
  logic [NUM_CH-1:0] pd_ff;
  logic [1:0] buf_eff_ff, gain_eff_ff;
  logic [15:0] frame_cnt_ff, abort_cnt_ff;
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic do_write;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Mapped register check, used by read and write paths
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == REG_STATUS) || (a == REG_COUNT) || (a == REG_CONTROL) ||
              (a >= REG_CODE_BASE && a <= REG_CODE_LAST && a[1:0] == 2'h0);
  endfunction

  // Pin synchronisers: link clock is sampled, not used as a clock
  odc_sync #(.W(4), .INIT(4'b1_1_0_1)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({sync_n, load_outputs_n, din, sclk}),
    .q({sync_n_s, load_n_s, din_s, sclk_s})
  );

  // Bit shifting and frame boundaries
  odc_shifter u_shift (
    .aclk(aclk),
    .aresetn(aresetn),
    .sclk_s(sclk_s),
    .din_s(din_s),
    .sync_n_s(sync_n_s),
    .word(word),
    .frame_done(frame_done),
    .frame_abort(frame_abort)
  );

  // Frame decode; software can mute the link
  assign is_data = frame_done && link_en_ff && !word[BIT_KIND];
  assign is_ctrl = frame_done && link_en_ff && word[BIT_KIND];
  assign fn = word[14:13];
  assign data_ch = word[14:12];
  assign data_val = word[CODE_W-1:0] & RES_MASK;
  assign ctrl_reset = is_ctrl && fn == FN_RESET;
  assign data_reset = ctrl_reset;
  assign load_now = !load_n_s || load_mode_ff == LDM_CONT || single_ff;

  // Single-update pulse after a load-mode word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      single_ff <= 1'b0;
    end else begin
      single_ff <= is_ctrl && fn == FN_LOAD && word[1:0] == LDM_SINGLE;
    end
  end

  // Per-channel input and output code registers
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          in_code_ff[gi] <= RST_CODE;
          out_code_ff[gi] <= RST_CODE;
          dirty_ff[gi] <= 1'b0;
        end else if (data_reset) begin
          in_code_ff[gi] <= RST_CODE;
          out_code_ff[gi] <= RST_CODE;
          dirty_ff[gi] <= 1'b0;
        end else begin
          // Writes land regardless of power-down
          if (is_data && data_ch == 3'(gi)) begin
            in_code_ff[gi] <= data_val;
            dirty_ff[gi] <= 1'b1;
          end else if (load_now && dirty_ff[gi]) begin
            dirty_ff[gi] <= 1'b0;
          end
          if (load_now && dirty_ff[gi]) begin
            out_code_ff[gi] <= in_code_ff[gi];
          end
        end
      end
      assign dac_code[gi*CODE_W +: CODE_W] = out_code_ff[gi];
    end
  endgenerate

  // Control settings; aborted frames never reach here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_ff <= RST_GROUP;
      buf_ff <= RST_GROUP;
      supply_ff <= RST_GROUP;
      load_mode_ff <= RST_LOAD_MODE;
      pd_ff <= RST_PDOWN;
    end else if (ctrl_reset && word[BIT_RESET_ALL]) begin
      gain_ff <= RST_GROUP;
      buf_ff <= RST_GROUP;
      supply_ff <= RST_GROUP;
      load_mode_ff <= RST_LOAD_MODE;
      pd_ff <= RST_PDOWN;
    end else if (is_ctrl) begin
      case (fn)
        FN_REF: begin
          supply_ff <= word[POS_SUPPLY +: 2];
          buf_ff <= word[POS_BUF +: 2];
          gain_ff <= word[POS_GAIN +: 2];
        end
        FN_LOAD: begin
          if (word[1:0] != LDM_RSVD) begin
            load_mode_ff <= word[1:0];
          end
        end
        FN_PDOWN: begin
          pd_ff <= word[NUM_CH-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Effective group setup: supply reference overrides
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_eff_ff <= RST_GROUP;
      gain_eff_ff <= RST_GROUP;
    end else begin
      buf_eff_ff <= buf_ff & ~supply_ff;
      gain_eff_ff <= gain_ff & ~supply_ff;
    end
  end

  assign chan_hiz = pd_ff;
  assign ref_buffered = buf_eff_ff;
  assign gain_double = gain_eff_ff;
  assign ref_supply = supply_ff;

  // Frame statistics
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_cnt_ff <= 16'h0000;
      abort_cnt_ff <= 16'h0000;
    end else begin
      if (frame_done && link_en_ff) begin
        frame_cnt_ff <= frame_cnt_ff + 16'h0001;
      end
      if (frame_abort && link_en_ff) begin
        abort_cnt_ff <= abort_cnt_ff + 16'h0001;
      end
    end
  end

  // AXI write channels: address and data taken in either order
  assign do_write = !awready_ff && !wready_ff && !bvalid_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        awready_ff <= 1'b0;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
        wready_ff <= 1'b0;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= reg_hit(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // Control register: bit 0 enables frame acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_en_ff <= RST_LINK_EN;
    end else if (do_write && awaddr_ff == REG_CONTROL && wstrb_ff[0]) begin
      link_en_ff <= wdata_ff[0];
    end
  end

  // AXI read channel: answer on the same edge that accepts the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else begin
      arready_ff <= !rvalid_ff && !(s_axi_arvalid && arready_ff);
      if (s_axi_arvalid && arready_ff) begin
        rvalid_ff <= 1'b1;
        rresp_ff <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        rdata_ff <= 32'h0000_0000;
        if (s_axi_araddr == REG_STATUS) begin
          rdata_ff <= {8'h00, dirty_ff, load_mode_ff, pd_ff,
                       gain_ff, buf_ff, supply_ff};
        end else if (s_axi_araddr == REG_COUNT) begin
          rdata_ff <= {abort_cnt_ff, frame_cnt_ff};
        end else if (s_axi_araddr == REG_CONTROL) begin
          rdata_ff <= {31'h0000_0000, link_en_ff};
        end else if (reg_hit(s_axi_araddr)) begin
          rdata_ff <= {20'h0_0000, out_code_ff[s_axi_araddr[4:2]]};
        end
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Checks
  sequence data_frame_s;
    is_data && !ctrl_reset;
  endsequence

  sequence pd_frame_s;
    is_ctrl && fn == FN_PDOWN;
  endsequence

  data_write_a: assert property (data_frame_s |=>
    in_code_ff[$past(data_ch)] == $past(data_val) && dirty_ff[$past(data_ch)])
    else $error("data frame did not load addressed input register");

  frame_abort_a: assert property (frame_abort |=>
    $stable(in_code_ff) && $stable(pd_ff) && $stable(load_mode_ff) && $stable(gain_ff))
    else $error("aborted frame changed state");

  low_bits_a: assert property ((in_code_ff[0] & ~RES_MASK) == '0)
    else $error("dropped low bits stored");

  supply_force_a: assert property ($past(supply_ff[0]) |->
    !buf_eff_ff[0] && !gain_eff_ff[0])
    else $error("supply group not forced unbuffered unity");

  pdown_map_a: assert property (pd_frame_s |=> pd_ff == $past(word[7:0]))
    else $error("power-down bits not applied");

  full_reset_a: assert property (ctrl_reset && word[BIT_RESET_ALL] |=>
    pd_ff == RST_PDOWN && load_mode_ff == LDM_LATCH && in_code_ff == '0 &&
    out_code_ff == '0)
    else $error("full reset incomplete");

  cont_load_a: assert property (load_mode_ff == LDM_CONT && !frame_done
    ##1 !frame_done |=> out_code_ff == in_code_ff)
    else $error("continuous mode outputs lag inputs");

  latched_hold_a: assert property (load_mode_ff == LDM_LATCH && load_n_s
    && !single_ff && !ctrl_reset |=> $stable(out_code_ff))
    else $error("latched outputs moved");

  single_upd_a: assert property (is_ctrl && fn == FN_LOAD &&
    word[1:0] == LDM_SINGLE && !load_n_s == 1'b0 ##1 single_ff |=> !single_ff)
    else $error("single update not one pulse");

  pd_keep_a: assert property ((pd_ff[0] && data_ch == 3'h0) and data_frame_s
    |=> in_code_ff[0] == $past(data_val))
    else $error("write lost during power-down");

  axi_read_a: assert property (s_axi_arvalid && arready_ff |=> rvalid_ff)
    else $error("read answer late");

  axi_write_a: assert property (do_write |=> bvalid_ff [*1])
    else $error("write answer late");
endmodule

// >>> verif/odc_host.sv
// Host serial port model that shifts command frames into the link pins
`timescale 1ns/1ps
module odc_host (
  // Link pins
  output logic sclk,
  output logic din,
  output logic sync_n
);
  // Idle link: clock parked high, strobe high
  initial begin
    sclk = 1'b1;
    din = 1'b0;
    sync_n = 1'b1;
  end

  // Shift n bits MSB first at 160 ns per bit, then close the frame
  task automatic send(input logic [15:0] w, input int n);
    #2; // Step off the sampling edge
    sync_n = 1'b0;
    #40;
    for (int i = 15; i > 15 - n; i--) begin
      din = w[i];
      #40 sclk = 1'b0;
      #80 sclk = 1'b1;
      #40;
    end
    sync_n = 1'b1;
    din = ~din; // Released line shows no stale value
  endtask
endmodule

// >>> verif/tb.sv
// Self-checking bench for the octal converter command logic
`timescale 1ns/1ps
module tb;
  import odc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic load_outputs_n = 1'b1;
  logic sclk, din, sync_n;
  logic [NUM_CH*CODE_W-1:0] dac_code;
  logic [NUM_CH-1:0] chan_hiz;
  logic [1:0] ref_buffered, ref_supply, gain_double;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [31:0] rdat;
  logic [1:0] resp;
  int n_mismatch = 0;
  int n_checks = 0;

  // 125 MHz clock
  always #4 aclk = ~aclk;

  odc_top #(.RES_BITS(12)) uut (
    .aclk(aclk), .aresetn(aresetn), .sclk(sclk), .din(din), .sync_n(sync_n),
    .load_outputs_n(load_outputs_n), .dac_code(dac_code), .chan_hiz(chan_hiz),
    .ref_buffered(ref_buffered), .ref_supply(ref_supply), .gain_double(gain_double),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  odc_host host (.sclk(sclk), .din(din), .sync_n(sync_n));

  // Value compare
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus write: address and data offered together, bready held until bvalid
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w, b;
    aw = 0;
    w = 0;
    b = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (s_axi_bvalid === 1'b1) b = 1;
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Bus read: rready held until rvalid
  task automatic axi_rd(input logic [7:0] a);
    bit ar, r;
    ar = 0;
    r = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r) begin
      @(posedge aclk);
      if (s_axi_rvalid === 1'b1) r = 1;
      if (!ar && s_axi_arready === 1'b1) begin
        ar = 1;
        s_axi_arvalid <= 1'b0;
      end
    end
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Read and compare with an OKAY response
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a);
    chk({resp, rdat}, {RESP_OKAY, exp});
  endtask

  // One frame, then time for the word to land
  task automatic frm(input logic [15:0] w, input int n);
    host.send(w, n);
    repeat (12) @(posedge aclk);
  endtask

  // Count summary and verdict
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard, well beyond the expected run of about 63 us
  initial begin
    #400_000;
    n_mismatch++;
    conclude;
  end

  // Test sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(dac_code, '0);
    chk({chan_hiz, ref_buffered, ref_supply, gain_double}, '0);
    rdc(REG_STATUS, 32'h0000_4000);
    rdc(REG_CONTROL, 32'h0000_0001);
    axi_rd(8'h10);
    chk({resp, rdat}, {RESP_SLVERR, 32'h0000_0000});
    axi_wr(8'h14, 32'hFFFF_FFFF);
    chk(resp, RESP_SLVERR);
    // Latched writes to all channels, then a load pulse
    for (int c = 0; c < NUM_CH; c++) begin
      frm({1'b0, 3'(c), 4'(c), 8'h5A}, 16);
    end
    chk(dac_code, '0);
    rdc(REG_STATUS, 32'h00FF_4000);
    load_outputs_n <= 1'b0;
    repeat (6) @(posedge aclk);
    load_outputs_n <= 1'b1;
    repeat (6) @(posedge aclk);
    for (int c = 0; c < NUM_CH; c++) begin
      chk(dac_code[12*c +: 12], {4'(c), 8'h5A});
      rdc(REG_CODE_BASE + 8'(4*c), {20'h0_0000, 4'(c), 8'h5A});
    end
    // Short frame is abandoned, disabled link ignores frames
    frm(16'h0FFF, 15);
    rdc(REG_STATUS, 32'h0000_4000);
    rdc(REG_COUNT, 32'h0001_0008);
    axi_wr(REG_CONTROL, 32'h0000_0000);
    frm(16'h0123, 16);
    rdc(REG_STATUS, 32'h0000_4000);
    axi_wr(REG_CONTROL, 32'h0000_0001);
    // Reference and gain setup, supply override
    frm(16'h803C, 16);
    chk({ref_buffered, gain_double, ref_supply}, 6'b11_11_00);
    frm(16'h803D, 16);
    chk({ref_buffered, gain_double, ref_supply}, 6'b10_10_01);
    // Load modes: continuous, latched, reserved, single update
    frm(16'hA000, 16);
    frm(16'h1FFF, 16);
    chk(dac_code[23:12], 12'hFFF);
    frm(16'hA001, 16);
    frm(16'hA003, 16);
    axi_rd(REG_STATUS);
    chk(rdat[15:14], LDM_LATCH);
    frm(16'h2ABC, 16);
    chk(dac_code[35:24], 12'h25A);
    frm(16'hA002, 16);
    chk(dac_code[35:24], 12'hABC);
    // Power-down keeps accepting codes
    frm(16'hC0A5, 16);
    chk(chan_hiz, 8'hA5);
    frm(16'hA000, 16);
    frm(16'h0777, 16);
    chk(dac_code[11:0], 12'h777);
    rdc(REG_CODE_BASE, 32'h0000_0777);
    // Data reset, then full reset
    frm(16'hE000, 16);
    chk(dac_code, '0);
    chk({chan_hiz, ref_supply}, {8'hA5, 2'b01});
    frm(16'hF000, 16);
    chk({chan_hiz, ref_buffered, ref_supply, gain_double}, '0);
    rdc(REG_STATUS, 32'h0000_4000);
    conclude;
  end
endmodule
